// ### rtl/etp_pkg.sv
// Constants shared by the energy-to-pulse converter pair.
// Assumes a 100 MHz metering clock and a special-register port with 8-bit addresses and 16-bit data.
`default_nettype none

package etp_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] MODE_ONE_ADDR = 8'h0B;
  localparam logic [7:0] MODE_TWO_ADDR = 8'h0C;
  localparam logic [7:0] NUM_A_ADDR    = 8'h27;
  localparam logic [7:0] DEN_A_ADDR    = 8'h28;
  localparam logic [7:0] NUM_B_ADDR    = 8'h29;
  localparam logic [7:0] DEN_B_ADDR    = 8'h2A;
  localparam logic [7:0] IRQ_EN_L_ADDR = 8'hD9;
  localparam logic [7:0] IRQ_EN_M_ADDR = 8'hDA;
  localparam logic [7:0] IRQ_EN_H_ADDR = 8'hDB;
  localparam logic [7:0] IRQ_ST_M_ADDR = 8'hDD;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int DIS_A_BIT   = 1;
  localparam int DIS_B_BIT   = 2;
  localparam int SEL_A_LSB   = 0;
  localparam int AMP_HR_BIT  = 3;
  localparam int SEL_B_LSB   = 4;
  localparam int FLAG_A_BIT  = 6;
  localparam int FLAG_B_BIT  = 7;
  localparam logic [7:0]  REG8_RST  = 8'h00;
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [15:0] IRQ_VECTOR = 16'h004B;

  // ****************************************
  // Source codes
  // ****************************************
  localparam logic [1:0] SRC_ACTIVE   = 2'h0;
  localparam logic [1:0] SRC_REACTIVE = 2'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ        = 100000;
  localparam int PULSE_LOW_MS   = 90;
  localparam int PERIOD_LONG_MS = 180;
  localparam int PULSE_LOW_CYC   = PULSE_LOW_MS * CLK_KHZ;
  localparam int PERIOD_LONG_CYC = PERIOD_LONG_MS * CLK_KHZ;
  localparam int CNT_W = 25;

  typedef enum logic [0:0] {
    ETP_IDLE = 1'b0,
    ETP_LOW  = 1'b1
  } etp_out_st_t;

endpackage

`default_nettype wire

// ### rtl/etp_energy_to_pulse.sv
// Two energy-to-pulse converters with their mode, scale and irq registers.
// Assumes one-cycle energy LSB strobes synchronous to sys_clk and a simple
// synchronous register port (write strobe, read strobe, registered data).
`default_nettype none

module etp_energy_to_pulse
  import etp_pkg::*;
#(
  parameter int unsigned LOW_CYC  = PULSE_LOW_CYC,
  parameter int unsigned LONG_CYC = PERIOD_LONG_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Energy LSB strobes and divider setting
  input  wire logic        active_lsb,
  input  wire logic        reactive_lsb,
  input  wire logic        apparent_lsb,
  input  wire logic        irms_lsb,
  input  wire logic [7:0]  energy_divider,
  // Pulse outputs and interrupt
  output logic             pulse_out_a_n,
  output logic             pulse_out_b_n,
  output logic             energy_irq,
  output logic      [15:0] energy_irq_vector
);

  localparam logic [CNT_W-1:0] LOW_W  = CNT_W'(LOW_CYC);
  localparam logic [CNT_W-1:0] LONG_W = CNT_W'(LONG_CYC);

  typedef struct packed {
    logic [7:0]              mode_one;
    logic [7:0]              mode_two;
    logic [7:0]              en_l;
    logic [7:0]              en_m;
    logic [7:0]              en_h;
    logic [1:0]              flag;
    logic [1:0][15:0]        num;
    logic [1:0][15:0]        den;
    logic [1:0][7:0]         pre;
    logic [1:0][15:0]        acc;
    logic [1:0][CNT_W-1:0]   per;
    logic [1:0][CNT_W-1:0]   low;
    etp_out_st_t [1:0]       st;
    logic [1:0]              fire;
    logic [1:0]              out_n;
    logic                    irq;
    logic [15:0]             rdata;
  } etp_state_t;

  etp_state_t s_q;
  etp_state_t s_d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic pick_src(input logic [1:0] sel,
                                    input logic       amp_hr,
                                    input logic       act,
                                    input logic       react,
                                    input logic       app,
                                    input logic       irms);
    logic r;
    r = 1'b0;
    if (sel == SRC_ACTIVE) begin
      r = act;
    end else if (sel == SRC_REACTIVE) begin
      r = react;
    end else begin
      r = amp_hr ? irms : app;
    end
    return r;
  endfunction

  function automatic logic [15:0] nz(input logic [15:0] v);
    return (v == 16'h0000) ? 16'h0001 : v;
  endfunction

  function automatic logic [CNT_W-1:0] low_width(
      input logic [CNT_W-1:0] period);
    logic [CNT_W-1:0] h;
    h = period >> 1;
    if (period >= LONG_W) begin
      h = LOW_W;
    end else if (h == '0) begin
      h = CNT_W'(1);
    end
    return h;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [1:0]   raw;
    logic         tick;
    logic [15:0]  n;
    logic [15:0]  e;
    logic [16:0]  sum;
    logic         dis;
    raw  = '0;
    tick = 1'b0;
    n    = '0;
    e    = '0;
    sum  = '0;
    dis  = 1'b0;
    s_d  = s_q;
    s_d.fire = '0;

    // Register writes; status clears before hardware sets below
    if (reg_wr) begin
      unique case (reg_addr)
        MODE_ONE_ADDR: s_d.mode_one = reg_wdata[7:0];
        MODE_TWO_ADDR: s_d.mode_two = reg_wdata[7:0];
        NUM_A_ADDR:    s_d.num[0] = reg_wdata;
        DEN_A_ADDR:    s_d.den[0] = reg_wdata;
        NUM_B_ADDR:    s_d.num[1] = reg_wdata;
        DEN_B_ADDR:    s_d.den[1] = reg_wdata;
        IRQ_EN_L_ADDR: s_d.en_l = reg_wdata[7:0];
        IRQ_EN_M_ADDR: s_d.en_m = reg_wdata[7:0];
        IRQ_EN_H_ADDR: s_d.en_h = reg_wdata[7:0];
        IRQ_ST_M_ADDR: s_d.flag = s_q.flag &
            reg_wdata[FLAG_B_BIT:FLAG_A_BIT];
        default: ;
      endcase
    end

    // Source choice; one amp-hour bit serves both converters
    raw[0] = pick_src(s_q.mode_two[SEL_A_LSB+:2],
                      s_q.mode_two[AMP_HR_BIT], active_lsb,
                      reactive_lsb, apparent_lsb, irms_lsb);
    raw[1] = pick_src(s_q.mode_two[SEL_B_LSB+:2],
                      s_q.mode_two[AMP_HR_BIT], active_lsb,
                      reactive_lsb, apparent_lsb, irms_lsb);

    for (int i = 0; i < 2; i++) begin
      // Energy divider: settings 0 and 1 pass every LSB
      tick = 1'b0;
      if (raw[i]) begin
        if (energy_divider <= 8'h01) begin
          tick = 1'b1;
          s_d.pre[i] = '0;
        end else if (s_q.pre[i] >= energy_divider - 8'h01) begin
          tick = 1'b1;
          s_d.pre[i] = '0;
        end else begin
          s_d.pre[i] = s_q.pre[i] + 8'h01;
        end
      end

      // Rate scaling by num/den with zero and ratio clamps
      n = nz(s_q.num[i]);
      e = nz(s_q.den[i]);
      if (n > e) begin
        n = e;
      end
      if (s_q.acc[i] >= e) begin
        s_d.acc[i] = '0;
      end
      if (tick) begin
        sum = {1'b0, s_q.acc[i]} + {1'b0, n};
        if (sum >= {1'b0, e}) begin
          s_d.acc[i]  = 16'(sum - {1'b0, e});
          s_d.fire[i] = 1'b1;
        end else begin
          s_d.acc[i] = sum[15:0];
        end
      end

      // Period measurement, saturating at the slow threshold; starting
      // at one makes the count at the next fire equal the full spacing
      if (s_d.fire[i]) begin
        s_d.per[i] = CNT_W'(1);
      end else if (s_q.per[i] < LONG_W) begin
        s_d.per[i] = s_q.per[i] + CNT_W'(1);
      end

      // Output shaping
      dis = (i == 0) ? s_q.mode_one[DIS_A_BIT] : s_q.mode_one[DIS_B_BIT];
      if (s_d.fire[i] && !dis) begin
        s_d.st[i]  = ETP_LOW;
        s_d.low[i] = low_width(s_q.per[i]);
        s_d.flag[i] = 1'b1;
      end else begin
        unique case (s_q.st[i])
          ETP_IDLE: s_d.low[i] = '0;
          ETP_LOW: begin
            if (dis || s_q.low[i] <= CNT_W'(1)) begin
              s_d.st[i]  = ETP_IDLE;
              s_d.low[i] = '0;
            end else begin
              s_d.low[i] = s_q.low[i] - CNT_W'(1);
            end
          end
        endcase
      end
      s_d.out_n[i] = (s_d.st[i] != ETP_LOW);
    end

    // Interrupt from enabled status flags
    s_d.irq = |(s_d.flag & s_d.en_m[FLAG_B_BIT:FLAG_A_BIT]);

    // Registered read data
    if (reg_rd) begin
      unique case (reg_addr)
        MODE_ONE_ADDR: s_d.rdata = {8'h00, s_q.mode_one};
        MODE_TWO_ADDR: s_d.rdata = {8'h00, s_q.mode_two};
        NUM_A_ADDR:    s_d.rdata = s_q.num[0];
        DEN_A_ADDR:    s_d.rdata = s_q.den[0];
        NUM_B_ADDR:    s_d.rdata = s_q.num[1];
        DEN_B_ADDR:    s_d.rdata = s_q.den[1];
        IRQ_EN_L_ADDR: s_d.rdata = {8'h00, s_q.en_l};
        IRQ_EN_M_ADDR: s_d.rdata = {8'h00, s_q.en_m};
        IRQ_EN_H_ADDR: s_d.rdata = {8'h00, s_q.en_h};
        IRQ_ST_M_ADDR: s_d.rdata = {8'h00, s_q.flag, 6'h00};
        default:       s_d.rdata = 16'h0000;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q          <= '0;
      s_q.mode_one <= REG8_RST;
      s_q.mode_two <= REG8_RST;
      s_q.num      <= {REG16_RST, REG16_RST};
      s_q.den      <= {REG16_RST, REG16_RST};
      s_q.st       <= '{ETP_IDLE, ETP_IDLE};
      s_q.out_n    <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse_out_a_n     = s_q.out_n[0];
  assign pulse_out_b_n     = s_q.out_n[1];
  assign energy_irq        = s_q.irq;
  assign reg_rdata         = s_q.rdata;
  assign energy_irq_vector = IRQ_VECTOR;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  flag_set_a: assert property (
      s_q.fire[0] && !s_q.mode_one[DIS_A_BIT]
      |-> s_q.flag[0] && !pulse_out_a_n)
    else $error("pulse A did not set flag or drive low");
  flag_b_a: assert property (
      s_q.fire[1] && !s_q.mode_one[DIS_B_BIT]
      |-> s_q.flag[1] && !pulse_out_b_n)
    else $error("pulse B did not set flag or drive low");
  irq_hold_a: assert property (
      s_q.irq && !reg_wr |=> s_q.irq)
    else $error("irq dropped without a register write");
  irq_gate_a: assert property (
      s_q.irq |-> |(s_q.flag & s_q.en_m[FLAG_B_BIT:FLAG_A_BIT]))
    else $error("irq raised with no enabled flag");
  flag_clear_a: assert property (
      reg_wr && reg_addr == IRQ_ST_M_ADDR && !reg_wdata[FLAG_A_BIT]
      && !s_d.fire[0] |=> !s_q.flag[0])
    else $error("status flag A not cleared by zero write");
  dis_quiet_a: assert property (
      $past(s_q.mode_one[DIS_A_BIT]) && s_q.mode_one[DIS_A_BIT]
      |-> pulse_out_a_n)
    else $error("disabled output A went low");
  idle_high_a: assert property (
      s_q.st[1] == ETP_IDLE |-> pulse_out_b_n)
    else $error("idle output B not high");

  // Scale, irq, width and vector
  property raw_fire_check;
    energy_divider <= 8'h01 && s_q.mode_two[SEL_B_LSB+:2] == SRC_ACTIVE
      && active_lsb && s_q.num[1] == 16'h0005 && s_q.den[1] == 16'h0002
      |=> s_q.fire[1];
  endproperty

  ratio_one_a: assert property (raw_fire_check)
    else $error("full ratio did not fire on each tick");
  sel_act_a: assert property (
      energy_divider <= 8'h01
      && s_q.mode_two[SEL_A_LSB+:2] == SRC_ACTIVE && active_lsb
      && s_q.num[0] == 16'h0000 && s_q.den[0] == 16'h0000
      |=> s_q.fire[0])
    else $error("active LSB did not give a pulse at unity ratio");
  vec_fix_a: assert property (energy_irq_vector == 16'h004B)
    else $error("irq vector changed");
  irq_first_a: assert property (
      s_q.fire[0] && !s_q.mode_one[DIS_A_BIT] && s_q.en_m[FLAG_A_BIT]
      |-> energy_irq)
    else $error("enabled pulse A did not raise irq");
  irq_second_a: assert property (
      s_q.fire[1] && !s_q.mode_one[DIS_B_BIT] && s_q.en_m[FLAG_B_BIT]
      |-> energy_irq)
    else $error("enabled pulse B did not raise irq");
  width_cap_a: assert property (
      s_q.low[0] <= LOW_W && s_q.low[1] <= LOW_W)
    else $error("pulse low width above the fixed slow width");

  // Main scenarios
  cov_pulse_a: cover property (s_q.fire[0] ##1 !pulse_out_a_n);
  cov_irq:     cover property (!s_q.irq ##1 s_q.irq);
  cov_clear:   cover property (s_q.irq ##1 !s_q.irq);
  cov_amp_hr:  cover property (s_q.mode_two[AMP_HR_BIT] && s_q.fire[1]);
  cov_divided: cover property (energy_divider > 8'h01 && s_q.fire[0]);

endmodule

`default_nettype wire

// ### test/etp_led_model.sv
// Calibration-equipment model watching one active-low pulse output.
// Assumes the output is looked at on the falling clock edge.
`default_nettype none

module etp_led_model (
  // Clock
  input  wire logic sys_clk,
  // Watched output
  input  wire logic led_n,
  // Observations
  output var  int   falls,
  output var  int   last_low
);
  timeunit 1ns;
  timeprecision 1ps;

  int   run = 0;
  logic prev = 1'b1;

  initial begin
    falls = 0;
    last_low = 0;
  end

  // Counts low starts and the length of the last low stretch
  always @(negedge sys_clk) begin
    if (prev === 1'b1 && led_n === 1'b0)
      falls++;
    if (led_n === 1'b0)
      run++;
    else if (run != 0) begin
      last_low = run;
      run = 0;
    end
    prev = led_n;
  end
endmodule

`default_nettype wire

// ### test/energy_to_pulse_converter_test.sv
// Self-checking bench for the energy-to-pulse converter pair.
// Assumes short pulse-width parameters and bench-side expected counts.
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  err_total++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
  end end

module energy_to_pulse_converter_test
  import etp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [3:0]  lsb = 4'h0;
  logic [7:0]  energy_divider = 8'h00;
  logic [15:0] rdata, vec, d;
  logic        oa_n, ob_n, irq;
  int          err_total = 0, checked = 0, cyc = 0;
  int          ea = 0, eb = 0, acc = 0, xa, xb, n, dv;

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  etp_energy_to_pulse #(.LOW_CYC(20), .LONG_CYC(40)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(rdata), .active_lsb(lsb[0]), .reactive_lsb(lsb[1]),
    .apparent_lsb(lsb[2]), .irms_lsb(lsb[3]),
    .energy_divider(energy_divider),
    .pulse_out_a_n(oa_n), .pulse_out_b_n(ob_n), .energy_irq(irq),
    .energy_irq_vector(vec)
  );

  etp_led_model u_led_a (.sys_clk(sys_clk), .led_n(oa_n),
                         .falls(), .last_low());
  etp_led_model u_led_b (.sys_clk(sys_clk), .led_n(ob_n),
                         .falls(), .last_low());

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    v = rdata;
  endtask

  task automatic hit(input int s, input int gap);
    @(negedge sys_clk);
    lsb[s] = 1'b1;
    @(negedge sys_clk);
    lsb = 4'h0;
    repeat (gap) @(negedge sys_clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'hF3D3BF2A));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    rd(MODE_TWO_ADDR, d);
    `CHK("mode_two reset", 16'h0000, d)
    rd(8'h10, d);
    `CHK("unmapped read", 16'h0000, d)
    `CHK("irq vector", IRQ_VECTOR, vec)
    wr(IRQ_EN_M_ADDR, 16'h00A5);
    rd(IRQ_EN_M_ADDR, d);
    `CHK("enable mid", 16'h00A5, d)
    wr(NUM_B_ADDR, 16'h0005);
    wr(DEN_B_ADDR, 16'h0002);
    rd(DEN_B_ADDR, d);
    `CHK("den b", 16'h0002, d)
    $display("test registers done");
    // Every select code with both amp-hour settings; B fixed at 1X
    for (int c = 0; c < 8; c++) begin
      wr(MODE_TWO_ADDR, 16'(((c & 4) << 1) | 8'h20 | (c & 3)));
      xb = (c & 4) ? 3 : 2;
      xa = (c & 2) ? xb : (c & 1);
      for (int s = 0; s < 4; s++) begin
        hit(s, 25);
        ea += (s == xa);
        eb += (s == xb);
        `CHK("falls a", ea, u_led_a.falls)
        `CHK("falls b", eb, u_led_b.falls)
      end
    end
    $display("test select done");
    wr(MODE_TWO_ADDR, 16'h0000);
    wr(IRQ_ST_M_ADDR, 16'h0000);
    wr(MODE_ONE_ADDR, 16'h0006);
    wr(IRQ_EN_M_ADDR, 16'h00C0);
    hit(0, 25);
    `CHK("disabled a", ea, u_led_a.falls)
    `CHK("disabled b", eb, u_led_b.falls)
    `CHK("irq off", 1'b0, irq)
    wr(MODE_ONE_ADDR, 16'h0004);
    hit(0, 0);
    ea++;
    `CHK("irq raised", 1'b1, irq)
    rd(IRQ_ST_M_ADDR, d);
    `CHK("status a", 16'h0040, d)
    wr(IRQ_ST_M_ADDR, 16'h00FF);
    `CHK("irq kept", 1'b1, irq)
    wr(IRQ_ST_M_ADDR, 16'h0000);
    `CHK("irq cleared", 1'b0, irq)
    wr(IRQ_EN_M_ADDR, 16'h0080);
    hit(0, 25);
    ea++;
    `CHK("irq masked", 1'b0, irq)
    $display("test irq done");
    repeat (45) @(negedge sys_clk);
    hit(0, 30);
    `CHK("slow width", 20, u_led_a.last_low)
    // The second pulse lands while the first is low and adds no fall
    repeat (4) hit(0, 8);
    ea += 3;
    `CHK("fast width", 5, u_led_a.last_low)
    `CHK("fast falls", ea, u_led_a.falls)
    $display("test width done");
    for (int t = 0; t < 4; t++) begin
      n = $urandom % 6;
      dv = $urandom % 6;
      wr(NUM_A_ADDR, 16'(n));
      wr(DEN_A_ADDR, 16'(dv));
      n = (n == 0) ? 1 : n;
      dv = (dv == 0) ? 1 : dv;
      n = (n > dv) ? dv : n;
      acc = (acc >= dv) ? 0 : acc;
      energy_divider = 8'($urandom % 2);
      for (int k = 0; k < 10; k++) begin
        hit(0, 25);
        acc += n;
        if (acc >= dv) begin
          acc -= dv;
          ea++;
        end
      end
      `CHK("ratio falls", ea, u_led_a.falls)
    end
    $display("test ratio done");
    energy_divider = 8'h03;
    wr(NUM_A_ADDR, 16'h0000);
    wr(DEN_A_ADDR, 16'h0000);
    repeat (6) hit(0, 25);
    ea += 2;
    `CHK("divided falls", ea, u_led_a.falls)
    $display("test divider done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
